// >>> logic/ea_gen_map.svh
// address bounds, step sizes and reset values for effective-address generation
`ifndef EA_GEN_MAP_SVH
`define EA_GEN_MAP_SVH
`define SFR_FLOOR        16'h0800
`define SP_RESET         16'h0800
`define WORD_STEP        16'h0002
`define BYTE_STEP        16'h0001
`define ADDR_CLEAR       16'h0000
`define LIMIT_ALIGN_MASK 16'hFFFE
`define BOOT_RAM_LO      16'h0800
`define BOOT_RAM_HI      16'h08FF
`define SECURE_RAM_LO    16'h0900
`define SECURE_RAM_HI    16'h09FF
`endif

// >>> logic/ea_gen_pkg.sv
// types shared by the effective-address generator and its testbench
package ea_gen_pkg;
    typedef enum logic [3:0] {
        MODE_FILE, MODE_DIRECT, MODE_INDIRECT, MODE_POST_INC, MODE_POST_DEC,
        MODE_PRE_INC, MODE_PRE_DEC, MODE_INDEXED, MODE_LIT_OFFSET,
        MODE_LIT_SHORT, MODE_LIT_LONG
    } ea_mode_t;
    typedef enum logic [2:0] {
        STACK_NONE, STACK_PUSH_DATA, STACK_PUSH_PC_LOW, STACK_PUSH_PC_CALL,
        STACK_PUSH_PC_EXC, STACK_POP
    } stack_op_t;
endpackage : ea_gen_pkg

// >>> logic/ea_check_if.sv
// carries a formed address to the stack and secure-RAM checkers
`timescale 1ns/100ps
interface ea_check_if;
    logic [15:0] ea;
    logic        sp_access;
    logic [15:0] limit;
    logic        trap_limit;
    logic        trap_under;
    logic        exec_boot;
    logic        exec_secure;
    logic        prot_boot;
    logic        prot_secure;
    logic        denied;
    modport gen       (output ea, sp_access, limit, exec_boot, exec_secure,
                       prot_boot, prot_secure,
                       input  trap_limit, trap_under, denied);
    modport stack_chk (input ea, sp_access, limit, output trap_limit, trap_under);
    modport ram_chk   (input ea, exec_boot, exec_secure, prot_boot, prot_secure,
                       output denied);
endinterface : ea_check_if

// >>> logic/stack_bound_check.sv
// compares stack-pointer addresses against the limit and the register-space floor
`timescale 1ns/100ps
`include "ea_gen_map.svh"
module stack_bound_check (
    ea_check_if.stack_chk chk
);
    // strict greater-than lets a push at the limit itself pass
    assign chk.trap_limit = chk.sp_access && (chk.ea > chk.limit);     // R6 R7
    assign chk.trap_under = chk.sp_access && (chk.ea < `SFR_FLOOR);    // R8
endmodule : stack_bound_check

// >>> logic/secure_ram_guard.sv
// refuses secure RAM segment access from code outside the owning flash segment
`timescale 1ns/100ps
`include "ea_gen_map.svh"
module secure_ram_guard (
    ea_check_if.ram_chk chk
);
    logic in_boot_ram;
    logic in_secure_ram;

    assign in_boot_ram   = (chk.ea >= `BOOT_RAM_LO) && (chk.ea <= `BOOT_RAM_HI);
    assign in_secure_ram = (chk.ea >= `SECURE_RAM_LO) && (chk.ea <= `SECURE_RAM_HI);
    assign chk.denied = (in_boot_ram && chk.prot_boot && !chk.exec_boot)          // R10
                     || (in_secure_ram && chk.prot_secure && !chk.exec_secure);  // R11
endmodule : secure_ram_guard

// >>> logic/stack_limit_and_ea_generation.sv
// effective-address generator with software-stack limit and underflow checking
// Summary of operation
// R1: register fifteen is stack pointer, grows upward
// R2: pop pre-decrements, push post-increments
// R3: call push clears pushed counter top bit
// R4: exception push joins status low byte
// R5: limit unreset, bit zero forced clear
// R6: every stack-pointer address compared with limit
// R7: push at limit passes; next push traps
// R8: address below register-space floor traps
// R9: software avoids stack read right after limit write
// R10: boot secure RAM only from boot code
// R11: secure RAM only from secure code
// R12: file address reaches near space directly
// R13: default result register is register zero
// R14: move reaches whole data space
// R15: first operand always register direct
// R16: indirect, modified and literal modes supported
// R17: indirect uses pointer unchanged
// R18: post-modify uses pointer then adjusts
// R19: pre-modify adjusts pointer then uses it
// R20: indexed adds pointer and offset register
// R21: literal offset adds pointer and literal
// R22: move shares one offset field
// R23: stack error is one-cycle trap request
`timescale 1ns/100ps
`include "ea_gen_map.svh"
module stack_limit_and_ea_generation
    import ea_gen_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic        REQ_VALID,
    input  wire ea_mode_t    REQ_MODE,
    input  wire logic [3:0]  REQ_PTR_SEL,
    input  wire logic [3:0]  REQ_BASE_SEL,
    input  wire logic [3:0]  REQ_DEST_SEL,
    input  wire logic        REQ_BYTE_OP,
    input  wire logic        REQ_MOVE,
    input  wire logic        REQ_DEST_FILE,
    input  wire logic        REQ_MULTIPLY,
    input  wire logic        REQ_MUL_PAIR,
    input  wire logic [15:0] PTR_VALUE,
    input  wire logic [15:0] OFFSET_VALUE,
    input  wire logic [15:0] LITERAL_VALUE,
    input  wire logic [12:0] FILE_ADDR,
    input  wire stack_op_t   STACK_OP,
    input  wire logic [15:0] PUSH_DATA,
    input  wire logic [23:0] PC_VALUE,
    input  wire logic [7:0]  STATUS_LOW_BYTE,
    input  wire logic        SP_WE,
    input  wire logic [15:0] SP_WDATA,
    input  wire logic        LIMIT_WE,
    input  wire logic [15:0] LIMIT_WDATA,
    input  wire logic        EXEC_IN_BOOT,
    input  wire logic        EXEC_IN_SECURE,
    input  wire logic        BOOT_RAM_PROT_EN,
    input  wire logic        SECURE_RAM_PROT_EN,
    output logic             EA_VALID,
    output logic [15:0]      EA_ADDR,
    output logic             PTR_UPDATE_VALID,
    output logic [3:0]       PTR_UPDATE_SEL,
    output logic [15:0]      PTR_UPDATE_VALUE,
    output logic [3:0]       OPERAND1_REG,
    output logic [15:0]      LITERAL_OUT,
    output logic [3:0]       RESULT_REG,
    output logic             RESULT_PAIR,
    output logic             RESULT_TO_FILE,
    output logic [15:0]      STACK_WRITE_DATA,
    output logic [15:0]      STACK_POINTER,
    output logic             STACK_TRAP,
    output logic             ACCESS_DENIED
);
    localparam logic [3:0] SP_INDEX   = 4'hF;
    localparam logic [3:0] WORK_INDEX = 4'h0;

    function automatic logic forms_ea(input ea_mode_t m);
        forms_ea = (m != MODE_DIRECT) && (m != MODE_LIT_SHORT) && (m != MODE_LIT_LONG);
    endfunction : forms_ea

    ea_check_if chk ();

    logic [15:0] stack_pointer_reg;
    logic [15:0] stack_limit_reg;
    logic [15:0] next_sp;
    logic [15:0] next_ea;
    logic [15:0] next_ptr;
    logic [15:0] next_push_word;
    logic [15:0] next_literal;
    logic [15:0] pointer_reg;
    logic [15:0] step;
    logic        stack_req;
    logic        push_req;
    logic        pop_req;
    logic        mode_req;
    logic        ptr_is_sp;
    logic        ptr_mod;
    logic        ea_req;
    logic        sp_access;

    assign stack_req = (STACK_OP != STACK_NONE);
    assign pop_req   = (STACK_OP == STACK_POP);
    assign push_req  = stack_req && !pop_req;
    // a stack operation owns the cycle; an addressing request alongside it is dropped
    assign mode_req  = REQ_VALID && !stack_req;
    assign ptr_is_sp = (REQ_PTR_SEL == SP_INDEX);                              // R1
    assign pointer_reg = ptr_is_sp ? stack_pointer_reg : PTR_VALUE;
    assign step = REQ_BYTE_OP ? `BYTE_STEP : `WORD_STEP;
    assign ptr_mod = (REQ_MODE == MODE_POST_INC) || (REQ_MODE == MODE_POST_DEC)
                  || (REQ_MODE == MODE_PRE_INC)  || (REQ_MODE == MODE_PRE_DEC);
    assign ea_req = mode_req && forms_ea(REQ_MODE);
    assign sp_access = stack_req || (ea_req && (REQ_MODE != MODE_FILE) && ptr_is_sp); // R6

    always_comb begin
        next_ea = `ADDR_CLEAR;
        if (push_req) begin
            next_ea = stack_pointer_reg;                                        // R2
        end else if (pop_req) begin
            next_ea = stack_pointer_reg - `WORD_STEP;                           // R2
        end else begin
            unique case (REQ_MODE)
                MODE_FILE:       next_ea = REQ_MOVE ? LITERAL_VALUE       // R14
                                                    : {3'h0, FILE_ADDR};  // R12
                MODE_INDIRECT,
                MODE_POST_INC,
                MODE_POST_DEC:   next_ea = pointer_reg;                 // R17 R18
                MODE_PRE_INC:    next_ea = pointer_reg + step;          // R19
                MODE_PRE_DEC:    next_ea = pointer_reg - step;          // R19
                MODE_INDEXED:    next_ea = pointer_reg + OFFSET_VALUE;  // R20 R22
                MODE_LIT_OFFSET: next_ea = pointer_reg + LITERAL_VALUE; // R21
                MODE_DIRECT,
                MODE_LIT_SHORT,
                MODE_LIT_LONG:   next_ea = `ADDR_CLEAR;
            endcase
        end
    end

    always_comb begin
        next_ptr = pointer_reg;
        unique case (REQ_MODE)
            MODE_POST_INC: next_ptr = pointer_reg + step;               // R18
            MODE_POST_DEC: next_ptr = pointer_reg - step;               // R18
            MODE_PRE_INC,
            MODE_PRE_DEC:  next_ptr = next_ea;                          // R19
            default:       next_ptr = pointer_reg;
        endcase
    end

    always_comb begin
        next_sp = stack_pointer_reg;
        if (push_req) begin
            next_sp = stack_pointer_reg + `WORD_STEP;                   // R2
        end else if (pop_req) begin
            next_sp = next_ea;                                          // R2
        end else if (mode_req && ptr_mod && ptr_is_sp) begin
            next_sp = next_ptr;
        end else if (SP_WE) begin
            next_sp = SP_WDATA;
        end
    end

    always_comb begin
        next_push_word = PUSH_DATA;
        unique case (STACK_OP)
            STACK_PUSH_PC_LOW:  next_push_word = PC_VALUE[15:0];
            STACK_PUSH_PC_CALL: next_push_word = {8'h00, 1'b0, PC_VALUE[22:16]};   // R3
            STACK_PUSH_PC_EXC:  next_push_word = {STATUS_LOW_BYTE, PC_VALUE[23:16]}; // R4
            default:            next_push_word = PUSH_DATA;
        endcase
    end

    assign next_literal = (REQ_MODE == MODE_LIT_SHORT) ? {11'h000, LITERAL_VALUE[4:0]}
                        : (REQ_MODE == MODE_LIT_LONG)  ? {6'h00, LITERAL_VALUE[9:0]}
                        : LITERAL_VALUE;                                            // R16

    assign chk.ea          = next_ea;
    assign chk.sp_access   = sp_access;
    assign chk.limit       = stack_limit_reg;
    assign chk.exec_boot   = EXEC_IN_BOOT;
    assign chk.exec_secure = EXEC_IN_SECURE;
    assign chk.prot_boot   = BOOT_RAM_PROT_EN;
    assign chk.prot_secure = SECURE_RAM_PROT_EN;

    stack_bound_check u_stack_check (
        .chk (chk.stack_chk)
    );

    secure_ram_guard u_ram_guard (
        .chk (chk.ram_chk)
    );

    // limit has no reset value; software must load it before using the stack
    always_ff @(posedge REF_CLK) begin
        if (LIMIT_WE) begin
            stack_limit_reg <= LIMIT_WDATA & `LIMIT_ALIGN_MASK;         // R5
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            stack_pointer_reg <= `SP_RESET;
        end else begin
            stack_pointer_reg <= next_sp;                               // R1 R2
        end
    end

    // the limit compare sees the registered limit, so a stack read in the
    // same cycle as a limit write is checked against the old value
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            STACK_TRAP <= 1'b0;
        end else begin
            STACK_TRAP <= chk.trap_limit || chk.trap_under;             // R9 R23
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            EA_VALID      <= 1'b0;
            EA_ADDR       <= `ADDR_CLEAR;
            ACCESS_DENIED <= 1'b0;
        end else begin
            EA_VALID      <= ea_req || stack_req;
            EA_ADDR       <= next_ea;
            ACCESS_DENIED <= (ea_req || stack_req) && chk.denied;       // R10 R11
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PTR_UPDATE_VALID <= 1'b0;
            PTR_UPDATE_SEL   <= WORK_INDEX;
            PTR_UPDATE_VALUE <= `ADDR_CLEAR;
        end else begin
            PTR_UPDATE_VALID <= (mode_req && ptr_mod) || stack_req;
            PTR_UPDATE_SEL   <= stack_req ? SP_INDEX : REQ_PTR_SEL;
            PTR_UPDATE_VALUE <= stack_req ? next_sp : next_ptr;         // R18 R19
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            OPERAND1_REG     <= WORK_INDEX;
            LITERAL_OUT      <= `ADDR_CLEAR;
            RESULT_REG       <= WORK_INDEX;
            RESULT_PAIR      <= 1'b0;
            RESULT_TO_FILE   <= 1'b0;
            STACK_WRITE_DATA <= `ADDR_CLEAR;
            STACK_POINTER    <= `SP_RESET;
        end else begin
            OPERAND1_REG     <= REQ_BASE_SEL;                                   // R15
            LITERAL_OUT      <= next_literal;                                   // R16
            RESULT_REG       <= REQ_MULTIPLY ? REQ_DEST_SEL
                              : (REQ_DEST_FILE ? WORK_INDEX : WORK_INDEX);      // R13
            RESULT_PAIR      <= REQ_MULTIPLY && REQ_MUL_PAIR;                   // R13
            RESULT_TO_FILE   <= REQ_DEST_FILE && !REQ_MULTIPLY;                 // R13
            STACK_WRITE_DATA <= next_push_word;
            STACK_POINTER    <= next_sp;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    sequence s_push_at_limit;
        push_req && (stack_pointer_reg == stack_limit_reg)
            && (stack_pointer_reg >= `SFR_FLOOR);
    endsequence
    sequence s_next_push;
        push_req [*1];
    endsequence

    a_push_grows: assert property (push_req |=>                          // R2
        STACK_POINTER == $past(stack_pointer_reg) + `WORD_STEP
        && EA_ADDR == $past(stack_pointer_reg))
        else $error("push did not use then advance pointer");
    a_pop_shrinks: assert property (pop_req |=>                          // R2
        EA_ADDR == $past(stack_pointer_reg) - `WORD_STEP && STACK_POINTER == EA_ADDR)
        else $error("pop did not pre-decrement pointer");
    a_call_msb_clear: assert property ((STACK_OP == STACK_PUSH_PC_CALL) |=> // R3
        STACK_WRITE_DATA[15:7] == 9'h000)
        else $error("call push kept counter top bit");
    a_exc_status: assert property ((STACK_OP == STACK_PUSH_PC_EXC) |=>   // R4
        STACK_WRITE_DATA == {$past(STATUS_LOW_BYTE), $past(PC_VALUE[23:16])})
        else $error("exception push lost status byte");
    a_limit_align: assert property (LIMIT_WE |=> stack_limit_reg[0] == 1'b0) // R5
        else $error("limit bit zero not cleared");
    // the push at the limit is checked on its own, not only as a guard of the next push
    a_limit_pass_then_trap: assert property (s_push_at_limit |=>         // R7 R23
        (!STACK_TRAP and (s_next_push |=> STACK_TRAP)))
        else $error("limit push sequence trapped wrongly");
    a_underflow_trap: assert property ((sp_access && next_ea < `SFR_FLOOR) |=> // R8 R23
        STACK_TRAP ##1 (!STACK_TRAP || $past(sp_access)))
        else $error("underflow not trapped in one cycle");
    a_floor_trap: assert property ((pop_req && stack_pointer_reg == `SFR_FLOOR) |=> // R8
        STACK_TRAP)
        else $error("pop below register-space floor not trapped");
    a_indirect_plain: assert property ((mode_req && REQ_MODE == MODE_INDIRECT) |=> // R17
        EA_VALID && EA_ADDR == $past(pointer_reg) && !PTR_UPDATE_VALID)
        else $error("indirect address altered");
    a_post_modify: assert property ((mode_req && REQ_MODE == MODE_POST_INC) |=> // R18
        EA_ADDR == $past(pointer_reg) && PTR_UPDATE_VALUE == EA_ADDR + $past(step))
        else $error("post-increment wrong");
    a_pre_modify: assert property ((mode_req && REQ_MODE == MODE_PRE_DEC) |=> // R19
        EA_ADDR == $past(pointer_reg) - $past(step) && PTR_UPDATE_VALUE == EA_ADDR)
        else $error("pre-decrement wrong");
    a_indexed_sum: assert property ((mode_req && REQ_MODE == MODE_INDEXED) |=> // R20
        EA_ADDR == $past(pointer_reg) + $past(OFFSET_VALUE))
        else $error("indexed sum wrong");
    a_file_near: assert property ((mode_req && REQ_MODE == MODE_FILE && !REQ_MOVE) |=> // R12
        EA_ADDR[15:13] == 3'h0)
        else $error("file address left near space");
endmodule : stack_limit_and_ea_generation

// >>> tb/pipe_reg_model.sv
// pipeline register-file model: supplies pointer contents and takes write-backs
`timescale 1ns/100ps
module pipe_reg_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  rd_sel,
    input  wire logic        wb_valid,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [15:0] wb_value,
    input  wire logic        load_en,
    input  wire logic [3:0]  load_sel,
    input  wire logic [15:0] load_value,
    output logic      [15:0] rd_value
);
    logic [15:0] regs [16];
    // read is combinational, so a write-back lands only one edge after the block reports it
    assign rd_value = regs[rd_sel];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) regs[i] <= 16'h0000;
        end else if (load_en) begin
            regs[load_sel] <= load_value;
        end else if (wb_valid) begin
            regs[wb_sel] <= wb_value;
        end
    end
endmodule : pipe_reg_model

// >>> tb/tb_stack_limit_and_ea_generation.sv
// self-checking bench for the effective-address generator with stack checking
`timescale 1ns/100ps
module tb_stack_limit_and_ea_generation;
    import ea_gen_pkg::*;
    logic ref_clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, byte_op = 1'b0, move = 1'b0;
    logic dest_file = 1'b0, multiply = 1'b0, mul_pair = 1'b0, sp_we = 1'b0, limit_we = 1'b0;
    logic exec_boot = 1'b0, exec_sec = 1'b0, boot_en = 1'b0, sec_en = 1'b0, load_en = 1'b0;
    logic [3:0] ptr_sel = 4'h0, base_sel = 4'h0, dest_sel = 4'h0, load_sel = 4'h0;
    logic [15:0] offset = 16'h0000, literal = 16'h0000, push_data = 16'h0000;
    logic [15:0] sp_wdata = 16'h0000, limit_wdata = 16'h0000, load_value = 16'h0000;
    logic [12:0] file_addr = 13'h0000;
    logic [23:0] pc = 24'h000000;
    logic [7:0]  status_low = 8'h00;
    ea_mode_t    req_mode = MODE_FILE;
    stack_op_t   stack_op = STACK_NONE;
    logic        ea_valid, upd_valid, res_pair, res_file, trap, denied;
    logic [3:0]  upd_sel, op1_reg, res_reg;
    logic [15:0] ptr_value, ea_addr, upd_value, lit_out, wdata, sp;
    int          failures = 0;
    int          check_count = 0;

    always #10 ref_clk = ~ref_clk;

    stack_limit_and_ea_generation stack_limit_and_ea_generation_inst (
        .REF_CLK(ref_clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_MODE(req_mode),
        .REQ_PTR_SEL(ptr_sel), .REQ_BASE_SEL(base_sel), .REQ_DEST_SEL(dest_sel),
        .REQ_BYTE_OP(byte_op), .REQ_MOVE(move), .REQ_DEST_FILE(dest_file),
        .REQ_MULTIPLY(multiply), .REQ_MUL_PAIR(mul_pair), .PTR_VALUE(ptr_value),
        .OFFSET_VALUE(offset), .LITERAL_VALUE(literal), .FILE_ADDR(file_addr),
        .STACK_OP(stack_op), .PUSH_DATA(push_data), .PC_VALUE(pc),
        .STATUS_LOW_BYTE(status_low), .SP_WE(sp_we), .SP_WDATA(sp_wdata),
        .LIMIT_WE(limit_we), .LIMIT_WDATA(limit_wdata), .EXEC_IN_BOOT(exec_boot),
        .EXEC_IN_SECURE(exec_sec), .BOOT_RAM_PROT_EN(boot_en), .SECURE_RAM_PROT_EN(sec_en),
        .EA_VALID(ea_valid), .EA_ADDR(ea_addr), .PTR_UPDATE_VALID(upd_valid),
        .PTR_UPDATE_SEL(upd_sel), .PTR_UPDATE_VALUE(upd_value), .OPERAND1_REG(op1_reg),
        .LITERAL_OUT(lit_out), .RESULT_REG(res_reg), .RESULT_PAIR(res_pair),
        .RESULT_TO_FILE(res_file), .STACK_WRITE_DATA(wdata), .STACK_POINTER(sp),
        .STACK_TRAP(trap), .ACCESS_DENIED(denied));

    pipe_reg_model pipe_reg_model_inst (
        .clk(ref_clk), .rst_n(resetn), .rd_sel(ptr_sel), .wb_valid(upd_valid),
        .wb_sel(upd_sel), .wb_value(upd_value), .load_en(load_en), .load_sel(load_sel),
        .load_value(load_value), .rd_value(ptr_value));

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // inputs change only at the falling edge; the answer is settled one falling edge later
    task automatic req(input stack_op_t op, input logic v, input ea_mode_t m);
        stack_op = op;
        req_valid = v;
        req_mode = m;
        @(negedge ref_clk);
    endtask : req

    task automatic load(input logic [3:0] s, input logic [15:0] v);
        load_sel = s;
        load_value = v;
        load_en = 1'b1;
        req(STACK_NONE, 1'b0, MODE_FILE);
        load_en = 1'b0;
    endtask : load

    task automatic push(input logic [15:0] s, input logic t);
        push_data = s ^ 16'h5A5A;
        req(STACK_PUSH_DATA, 1'b0, MODE_FILE);
        check(ea_addr, s);
        check(sp, s + 16'h0002);
        check(wdata, s ^ 16'h5A5A);
        check(trap, t);
    endtask : push

    task automatic set_sp_limit(input logic [15:0] s, input logic [15:0] l);
        sp_wdata = s;
        limit_wdata = l;
        sp_we = 1'b1;
        limit_we = 1'b1;
        req(STACK_NONE, 1'b0, MODE_FILE);
        sp_we = 1'b0;
        limit_we = 1'b0;
        req(STACK_NONE, 1'b0, MODE_FILE);
    endtask : set_sp_limit

    task automatic test_modes();
        ea_mode_t    ms [7] = '{MODE_INDIRECT, MODE_POST_INC, MODE_POST_DEC, MODE_PRE_INC,
                                MODE_PRE_DEC, MODE_INDEXED, MODE_LIT_OFFSET};
        logic [15:0] p = 16'h1230;
        logic [15:0] np, ea;
        load(4'h3, p);
        ptr_sel = 4'h3;
        offset = 16'h0104;
        literal = 16'h0022;
        for (int i = 0; i < 7; i++) begin
            byte_op = (i == 4);
            base_sel = 4'(i + 1);
            np = (i == 1 || i == 3) ? p + 16'h0002 : (i == 2) ? p - 16'h0002 :
                 (i == 4) ? p - 16'h0001 : p;
            ea = (i == 3 || i == 4) ? np : (i == 5) ? p + offset : (i == 6) ? p + literal : p;
            req(STACK_NONE, 1'b1, ms[i]);
            check(ea_addr, ea);
            check({ea_valid, op1_reg}, {1'b1, 4'(i + 1)});
            if (np != p) check({upd_valid, upd_sel, upd_value}, {1'b1, 4'h3, np});
            req(STACK_NONE, 1'b0, MODE_FILE);
            p = np;
        end
        $display("test modes done");
    endtask : test_modes

    task automatic test_file();
        file_addr = 13'h1FFF;
        dest_file = 1'b1;
        req(STACK_NONE, 1'b1, MODE_FILE);
        check(ea_addr, 16'h1FFF);
        check({res_reg, res_file}, {4'h0, 1'b1});
        move = 1'b1;
        literal = 16'hF00E;
        req(STACK_NONE, 1'b1, MODE_FILE);
        check(ea_addr, 16'hF00E);
        move = 1'b0;
        multiply = 1'b1;
        mul_pair = 1'b1;
        dest_sel = 4'h6;
        req(STACK_NONE, 1'b1, MODE_DIRECT);
        check({res_reg, res_pair, res_file}, {4'h6, 1'b1, 1'b0});
        multiply = 1'b0;
        literal = 16'hFFFF;
        req(STACK_NONE, 1'b1, MODE_LIT_SHORT);
        check(lit_out, 16'h001F);
        req(STACK_NONE, 1'b1, MODE_LIT_LONG);
        check(lit_out, 16'h03FF);
        req(STACK_NONE, 1'b0, MODE_FILE);
        $display("test file done");
    endtask : test_file

    task automatic test_secure();
        load(4'h4, 16'h0810);
        load(4'h5, 16'h0920);
        for (int i = 0; i < 4; i++) begin
            boot_en = (i < 2);
            sec_en = (i >= 2);
            exec_boot = (i == 1);
            exec_sec = (i == 3);
            ptr_sel = (i < 2) ? 4'h4 : 4'h5;
            req(STACK_NONE, 1'b1, MODE_INDIRECT);
            check(denied, (i == 0 || i == 2));
        end
        req(STACK_NONE, 1'b0, MODE_FILE);
        $display("test secure done");
    endtask : test_secure

    task automatic test_limit();
        set_sp_limit(16'h0800, 16'h0805);
        push(16'h0800, 1'b0);
        push(16'h0802, 1'b0);
        ptr_sel = 4'hF;
        literal = 16'h0001;
        // 0x0805 passes against the raw value but must trap once bit zero is cleared
        req(STACK_NONE, 1'b1, MODE_LIT_OFFSET);
        check({ea_addr, trap}, {16'h0805, 1'b1});
        push(16'h0804, 1'b0);
        push(16'h0806, 1'b1);
        req(STACK_NONE, 1'b0, MODE_FILE);
        check(trap, 1'b0);
        set_sp_limit(16'h0806, 16'h0805);
        req(STACK_POP, 1'b0, MODE_FILE);
        check({ea_addr, sp, trap}, {16'h0804, 16'h0804, 1'b0});
        $display("test limit done");
    endtask : test_limit

    task automatic test_pc();
        set_sp_limit(16'h0A00, 16'hFFFE);
        pc = 24'h9A1234;
        status_low = 8'hA5;
        req(STACK_PUSH_PC_LOW, 1'b0, MODE_FILE);
        check({ea_addr, wdata}, {16'h0A00, 16'h1234});
        req(STACK_PUSH_PC_CALL, 1'b0, MODE_FILE);
        check({ea_addr, wdata}, {16'h0A02, 16'h001A});
        req(STACK_PUSH_PC_LOW, 1'b0, MODE_FILE);
        req(STACK_PUSH_PC_EXC, 1'b0, MODE_FILE);
        check({ea_addr, wdata}, {16'h0A06, 16'hA59A});
        set_sp_limit(16'h07FE, 16'hFFFE);
        push(16'h07FE, 1'b1);
        req(STACK_NONE, 1'b0, MODE_FILE);
        check(trap, 1'b0);
        req(STACK_POP, 1'b0, MODE_FILE);
        check({ea_addr, sp, trap}, {16'h07FE, 16'h07FE, 1'b1});
        req(STACK_NONE, 1'b0, MODE_FILE);
        check(trap, 1'b0);
        $display("test pc and underflow done");
    endtask : test_pc

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge ref_clk);
        check({sp, ea_valid, trap}, {16'h0800, 1'b0, 1'b0});
        resetn = 1'b1;
        test_modes();
        test_file();
        test_secure();
        test_limit();
        test_pc();
        give_verdict();
    end
endmodule : tb_stack_limit_and_ea_generation
